/* src/lcig_pkg.sv */
// Package with register map, field layout and constants of the logic cell input stage.
package lcig_pkg;

    // Register byte offsets on the 32-bit Wishbone bus.
    localparam logic [7:0] LCIG_SEL0_OFS   = 8'h00;
    localparam logic [7:0] LCIG_SEL1_OFS   = 8'h04;
    localparam logic [7:0] LCIG_SEL2_OFS   = 8'h08;
    localparam logic [7:0] LCIG_SEL3_OFS   = 8'h0C;
    localparam logic [7:0] LCIG_GLS0_OFS   = 8'h10;
    localparam logic [7:0] LCIG_POL_OFS    = 8'h14;
    localparam logic [7:0] LCIG_STAT_OFS   = 8'h18;

    // Widths.
    localparam int LCIG_ADDR_W    = 8;
    localparam int LCIG_DATA_W    = 32;
    localparam int LCIG_CODE_W    = 5;
    localparam int LCIG_NUM_IN    = 4;
    localparam int LCIG_NUM_SRC   = 32;
    localparam int LCIG_REG_W     = 8;

    // Field positions.
    localparam int LCIG_CODE_LSB        = 0;
    localparam int LCIG_GATE0_INV_BIT   = 0;
    localparam int LCIG_CELL_INV_BIT    = 7;
    localparam int LCIG_STAT_GATE_BIT   = 4;
    localparam int LCIG_STAT_CELL_BIT   = 5;

    // Reset values: power-on clears everything, other resets touch only the cell polarity.
    localparam logic [4:0] LCIG_CODE_RST      = 5'h00;
    localparam logic [7:0] LCIG_GLS_RST       = 8'h00;
    localparam logic       LCIG_CELL_INV_RST  = 1'b0;
    localparam logic       LCIG_GATE_INV_RST  = 1'b0;

    typedef logic [LCIG_CODE_W-1:0] lcig_code_t;
    typedef enum logic {
        LCIG_BUS_IDLE,
        LCIG_BUS_ACK
    } lcig_bus_e;

endpackage : lcig_pkg

/* src/lcig_cfg_if.sv */
// Interface carrying configuration and data inputs between the cell modules.
`timescale 1ns/1ns
interface lcig_cfg_if;
    import lcig_pkg::*;
    lcig_code_t                 code [LCIG_NUM_IN];  // Source code per data input.
    logic [LCIG_REG_W-1:0]      gls0;                // Gate 0 term enables.
    logic                       gate0_invert;        // Gate 0 polarity.
    logic [LCIG_NUM_IN-1:0]     data_in;             // Selected cell data inputs.
    logic                       gate0_out;           // Gate 0 after polarity.

    modport ctrl (
        output code,
        output gls0,
        output gate0_invert,
        input  data_in,
        input  gate0_out
    );
    modport mux (
        input  code,
        output data_in
    );
    modport gate (
        input  gls0,
        input  gate0_invert,
        input  data_in,
        output gate0_out
    );
endinterface : lcig_cfg_if

/* src/lcig_src_mux.sv */
// Four source selectors picking the cell data inputs from the source bus.
`timescale 1ns/1ns
module lcig_src_mux
    import lcig_pkg::*;
(
    input  wire logic [LCIG_NUM_SRC-1:0] src_i,  // Candidate source signals.
    lcig_cfg_if.mux                       cfg     // Codes in, data inputs out.
);
    genvar g;
    generate
        for (g = 0; g < LCIG_NUM_IN; g++) begin : g_sel
            // Each code indexes one source; all 32 codes are legal.
            assign cfg.data_in[g] = src_i[cfg.code[g]];  // see RULE_01 see RULE_02 see RULE_03 see RULE_04
        end
    endgenerate
endmodule : lcig_src_mux

/* src/lcig_gate0.sv */
// Gate 0: OR of enabled true and inverted data terms, then gate polarity.
`timescale 1ns/1ns
module lcig_gate0
    import lcig_pkg::*;
(
    lcig_cfg_if.gate cfg  // Enables and data in, gate output out.
);
    logic [LCIG_REG_W-1:0] terms;
    genvar g;
    generate
        for (g = 0; g < LCIG_NUM_IN; g++) begin : g_term
            // Odd bit gates the true form, even bit the inverted form.
            assign terms[2*g+1] = cfg.gls0[2*g+1] & cfg.data_in[g];   // see RULE_06 see RULE_07 see RULE_08 see RULE_09
            assign terms[2*g]   = cfg.gls0[2*g] & ~cfg.data_in[g];    // see RULE_06 see RULE_07 see RULE_08 see RULE_09
        end
    endgenerate
    assign cfg.gate0_out = (|terms) ^ cfg.gate0_invert;  // see RULE_13 see RULE_11
endmodule : lcig_gate0

/* src/lcig_top.sv */
// Logic cell input stage: Wishbone registers, source selectors, gate 0 and output polarity.
// Operation
// RULE_01: Five-bit code selects source of input 1.
// RULE_02: Five-bit code selects source of input 2.
// RULE_03: Five-bit code selects source of input 3.
// RULE_04: Five-bit code selects source of input 4.
// RULE_05: Select register upper three bits read zero.
// RULE_06: Bits 7/6 gate input 4 true/inverted.
// RULE_07: Bits 5/4 gate input 3 true/inverted.
// RULE_08: Bits 3/2 gate input 2 true/inverted.
// RULE_09: Bits 1/0 gate input 1 true/inverted.
// RULE_10: Config bits read/write, kept across ordinary reset; the cell polarity bit is cleared by ordinary reset here.
// RULE_11: Gate polarity bit inverts gate 0 output.
// RULE_12: Cell polarity bit inverts final cell output.
// RULE_13: Gate 0 is OR of enabled terms.
`timescale 1ns/1ns
module lcig_top
    import lcig_pkg::*;
(
    input  wire logic                       clk_i,     // System clock, 10 MHz.
    input  wire logic                       rst_i,     // Ordinary reset, sync, active high.
    input  wire logic                       por_i,     // Power-on or brown-out reset, sync.
    input  wire logic                       cyc_i,     // Wishbone cycle.
    input  wire logic                       stb_i,     // Wishbone strobe.
    input  wire logic                       we_i,      // Wishbone write enable.
    input  wire logic [lcig_pkg::LCIG_ADDR_W-1:0] adr_i,  // Wishbone byte address.
    input  wire logic [3:0]                 sel_i,     // Wishbone byte selects.
    input  wire logic [lcig_pkg::LCIG_DATA_W-1:0] dat_i,  // Wishbone write data.
    output logic      [lcig_pkg::LCIG_DATA_W-1:0] dat_o,  // Wishbone read data.
    output logic                            ack_o,     // Wishbone acknowledge.
    input  wire logic [lcig_pkg::LCIG_NUM_SRC-1:0] src_i, // Candidate source signals.
    output logic      [lcig_pkg::LCIG_NUM_IN-1:0]  data_in_o, // Registered cell data inputs.
    output logic                            gate0_o,   // Registered gate 0 output.
    output logic                            cell_out_o // Registered cell output.
);
    import lcig_pkg::*;

    lcig_cfg_if cfg ();

    lcig_bus_e             bus_reg;
    lcig_bus_e             bus_next;
    lcig_code_t            code_reg [LCIG_NUM_IN];
    logic [LCIG_REG_W-1:0] gls0_reg;
    logic                  gate_inv_reg;
    logic                  cell_inv_reg;
    logic [LCIG_DATA_W-1:0] rdata_reg;
    logic [LCIG_DATA_W-1:0] rdata_next;
    logic [LCIG_NUM_IN-1:0] data_in_reg;
    logic                  gate0_reg;
    logic                  cell_out_reg;
    logic                  cell_out_next;
    logic                  req;
    logic                  wr_commit;
    logic                  lane0_wr;

    // Returns true when the bus address hits the given register offset.
    function automatic logic hit(input logic [LCIG_ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Returns the select register index for an address, or LCIG_NUM_IN when not a select.
    function automatic int sel_index(input logic [LCIG_ADDR_W-1:0] a);
        int idx;
        idx = LCIG_NUM_IN;
        if (hit(a, LCIG_SEL0_OFS)) begin
            idx = 0;
        end else if (hit(a, LCIG_SEL1_OFS)) begin
            idx = 1;
        end else if (hit(a, LCIG_SEL2_OFS)) begin
            idx = 2;
        end else if (hit(a, LCIG_SEL3_OFS)) begin
            idx = 3;
        end
        sel_index = idx;
    endfunction : sel_index

    // Submodules.
    lcig_src_mux u_mux (
        .src_i (src_i),
        .cfg   (cfg.mux)
    );

    lcig_gate0 u_gate (
        .cfg (cfg.gate)
    );

    genvar g;
    generate
        for (g = 0; g < LCIG_NUM_IN; g++) begin : g_code
            assign cfg.code[g] = code_reg[g];
        end
    endgenerate
    assign cfg.gls0         = gls0_reg;
    assign cfg.gate0_invert = gate_inv_reg;

    // Bus handshake: answer one cycle after the request, drop ack the cycle after.
    assign req       = cyc_i & stb_i;
    assign wr_commit = req & we_i & (bus_reg == LCIG_BUS_ACK);
    assign lane0_wr  = wr_commit & sel_i[0];

    always_comb begin
        bus_next = bus_reg;
        case (bus_reg)
            LCIG_BUS_IDLE: begin
                if (req) begin
                    bus_next = LCIG_BUS_ACK;
                end
            end
            LCIG_BUS_ACK: begin
                bus_next = LCIG_BUS_IDLE;
            end
            default: begin
                bus_next = LCIG_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            bus_reg <= LCIG_BUS_IDLE;
        end else begin
            bus_reg <= bus_next;
        end
    end

    assign ack_o = (bus_reg == LCIG_BUS_ACK);

    // Source codes survive an ordinary reset; only power-on clears them.
    generate
        for (g = 0; g < LCIG_NUM_IN; g++) begin : g_code_reg
            always_ff @(posedge clk_i) begin
                if (por_i) begin
                    code_reg[g] <= LCIG_CODE_RST;  // see RULE_10
                end else if (lane0_wr && sel_index(adr_i) == g) begin
                    code_reg[g] <= dat_i[LCIG_CODE_LSB +: LCIG_CODE_W];  // see RULE_01 see RULE_02 see RULE_03 see RULE_04
                end
            end
        end
    endgenerate

    // Gate 0 term enables, also untouched by an ordinary reset.
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            gls0_reg <= LCIG_GLS_RST;  // see RULE_10
        end else if (lane0_wr && hit(adr_i, LCIG_GLS0_OFS)) begin
            gls0_reg <= dat_i[LCIG_REG_W-1:0];  // see RULE_10
        end
    end

    // Gate polarity is kept across ordinary reset; cell polarity is cleared by every reset.
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            gate_inv_reg <= LCIG_GATE_INV_RST;
        end else if (lane0_wr && hit(adr_i, LCIG_POL_OFS)) begin
            gate_inv_reg <= dat_i[LCIG_GATE0_INV_BIT];  // see RULE_11
        end
    end

    always_ff @(posedge clk_i) begin
        if (por_i || rst_i) begin
            cell_inv_reg <= LCIG_CELL_INV_RST;
        end else if (lane0_wr && hit(adr_i, LCIG_POL_OFS)) begin
            cell_inv_reg <= dat_i[LCIG_CELL_INV_BIT];  // see RULE_12
        end
    end

    // Read data is captured as the request is taken, so it stands with ack.
    always_comb begin
        int idx;
        idx = sel_index(adr_i);
        rdata_next = '0;
        if (idx < LCIG_NUM_IN) begin
            rdata_next[LCIG_CODE_LSB +: LCIG_CODE_W] = code_reg[idx[1:0]];  // see RULE_05
        end else if (hit(adr_i, LCIG_GLS0_OFS)) begin
            rdata_next[LCIG_REG_W-1:0] = gls0_reg;  // see RULE_10
        end else if (hit(adr_i, LCIG_POL_OFS)) begin
            rdata_next[LCIG_CELL_INV_BIT]  = cell_inv_reg;
            rdata_next[LCIG_GATE0_INV_BIT] = gate_inv_reg;
        end else if (hit(adr_i, LCIG_STAT_OFS)) begin
            rdata_next[LCIG_NUM_IN-1:0]   = data_in_reg;
            rdata_next[LCIG_STAT_GATE_BIT] = gate0_reg;
            rdata_next[LCIG_STAT_CELL_BIT] = cell_out_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            rdata_reg <= '0;
        end else if (req && bus_reg == LCIG_BUS_IDLE && !we_i) begin
            rdata_reg <= rdata_next;
        end
    end

    assign dat_o = rdata_reg;

    // Output stage: gate 0 stands in for the logic function, then cell polarity.
    assign cell_out_next = cfg.gate0_out ^ cell_inv_reg;  // see RULE_12

    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            data_in_reg  <= '0;
            gate0_reg    <= 1'b0;
            cell_out_reg <= 1'b0;
        end else begin
            data_in_reg  <= cfg.data_in;
            gate0_reg    <= cfg.gate0_out;  // see RULE_13
            cell_out_reg <= cell_out_next;
        end
    end

    assign data_in_o  = data_in_reg;
    assign gate0_o    = gate0_reg;
    assign cell_out_o = cell_out_reg;

endmodule : lcig_top

/* dv/lcig_top_chk.sv */
// Port checker of the logic cell input stage, bound to its top module.
`timescale 1ns/1ns
module lcig_top_chk
    import lcig_pkg::*;
(
    input wire logic        clk_i,      // Clock.
    input wire logic        rst_i,      // Reset.
    input wire logic        por_i,      // Power-on reset.
    input wire logic        cyc_i,      // Cycle.
    input wire logic        stb_i,      // Strobe.
    input wire logic        we_i,       // Write.
    input wire logic [7:0]  adr_i,      // Address.
    input wire logic [3:0]  sel_i,      // Selects.
    input wire logic [31:0] dat_i,      // Write data.
    input wire logic [31:0] dat_o,      // Read data.
    input wire logic        ack_o,      // Acknowledge.
    input wire logic [31:0] src_i,      // Sources.
    input wire logic [3:0]  data_in_o,  // Data inputs.
    input wire logic        gate0_o,    // Gate 0.
    input wire logic        cell_out_o  // Cell output.
);
    lcig_code_t code_reg [4];
    logic [7:0] gls_reg;
    logic       ginv_reg;
    logic       cinv_reg;
    logic [1:0] settle_reg;
    logic [3:0] din;
    logic       g0;
    logic       wr;
    logic       rdx;
    assign wr  = ack_o && we_i && sel_i[0];
    assign rdx = ack_o && !we_i;
    always_comb begin
        for (int k = 0; k < 4; k++) din[k] = src_i[code_reg[k]];
    end
    assign g0 = (|(gls_reg & {din[3], ~din[3], din[2], ~din[2], din[1], ~din[1], din[0],
                ~din[0]})) ^ ginv_reg;
    // Shadow copies of the configuration, so outputs can be predicted.
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            code_reg <= '{default: 5'h00};
            gls_reg  <= 8'h00;
            ginv_reg <= 1'b0;
            cinv_reg <= 1'b0;
        end else if (rst_i) begin
            cinv_reg <= 1'b0;
        end else if (wr && adr_i < LCIG_GLS0_OFS && adr_i[1:0] == 2'h0) begin
            code_reg[adr_i[3:2]] <= dat_i[4:0];
        end else if (wr && adr_i == LCIG_GLS0_OFS) begin
            gls_reg <= dat_i[7:0];
        end else if (wr && adr_i == LCIG_POL_OFS) begin
            ginv_reg <= dat_i[0];
            cinv_reg <= dat_i[7];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) settle_reg <= 2'h0;
        else if (settle_reg != 2'h2) settle_reg <= settle_reg + 2'h1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || por_i);
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_ack_latency: assert property ($rose(cyc_i && stb_i) |=> ack_o) else $error("ack late");
    a_sel_readback: assert property (rdx && adr_i < LCIG_GLS0_OFS && adr_i[1:0] == 2'h0
        |-> dat_o == {27'h0, code_reg[adr_i[3:2]]}) else $error("select readback");
    a_gls_readback: assert property (rdx && adr_i == LCIG_GLS0_OFS
        |-> dat_o == {24'h0, gls_reg}) else $error("gate enables readback");
    a_pol_readback: assert property (rdx && adr_i == LCIG_POL_OFS
        |-> dat_o == {24'h0, cinv_reg, 6'h0, ginv_reg}) else $error("polarity readback");
    a_unmapped_zero: assert property (rdx && adr_i > LCIG_STAT_OFS |-> dat_o == 32'h0)
        else $error("unmapped read");
    a_data_select: assert property (settle_reg == 2'h2 |-> data_in_o == $past(din))
        else $error("data input select");
    a_gate_terms: assert property (settle_reg == 2'h2 |-> gate0_o == $past(g0))
        else $error("gate 0 value");
    a_cell_invert: assert property (settle_reg == 2'h2 |-> cell_out_o == $past(g0 ^ cinv_reg))
        else $error("cell output");
    // Status is captured as the read is taken, so it shows the outputs of the cycle before ack.
    a_stat_readback: assert property (rdx && adr_i == LCIG_STAT_OFS
        |-> dat_o == {26'h0, $past(cell_out_o), $past(gate0_o), $past(data_in_o)})
        else $error("status readback");
    c_gls_write: cover property (wr && adr_i == LCIG_GLS0_OFS);
    c_pol_read: cover property (rdx && adr_i == LCIG_POL_OFS && dat_o[7]);
    c_gate_high: cover property (settle_reg == 2'h2 && gate0_o);
endmodule : lcig_top_chk
bind lcig_top lcig_top_chk lcig_top_chk_i (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .src_i(src_i), .data_in_o(data_in_o), .gate0_o(gate0_o),
    .cell_out_o(cell_out_o));

/* dv/lcig_top_bench.sv */
// Self-checking bench of the logic cell input stage.
`timescale 1ns/1ns
module lcig_top_bench;
    import lcig_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        por_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] src_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [3:0]  data_in_o;
    logic        gate0_o;
    logic        cell_out_o;
    logic [31:0] rd;
    int          errors = 0;
    int          cmp_count = 0;
    lcig_code_t  codes [4] = '{5'h03, 5'h0C, 5'h11, 5'h1F};

    always #50 clk_i = ~clk_i;

    lcig_top lcig_top_i (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .src_i(src_i), .data_in_o(data_in_o),
        .gate0_o(gate0_o), .cell_out_o(cell_out_o));

    task automatic stop_test();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            errors++;
            stop_test();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : bus

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        check(name, rd, exp);
    endtask : rdchk

    // Drives the selected sources to d, then compares the registered outputs.
    task automatic outs(input logic [3:0] d, input logic g, input logic c);
        logic [31:0] v = 32'h0;
        for (int k = 0; k < 4; k++) v[codes[k]] = d[k];
        @(posedge clk_i);
        src_i <= v;
        repeat (2) @(posedge clk_i);
        check("data_in", {28'h0, data_in_o}, {28'h0, d});
        check("gate0", {31'h0, gate0_o}, {31'h0, g});
        check("cell", {31'h0, cell_out_o}, {31'h0, c});
    endtask : outs

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 8'(4 * k), {27'h7FFFFFF, codes[k]}, 4'hF);
            rdchk("sel", 8'(4 * k), {27'h0, codes[k]});
        end
        for (int v = 0; v < 16; v++) outs(4'(v), 1'b0, 1'b0);
        for (int b = 0; b < 8; b++) begin
            bus(1'b1, LCIG_GLS0_OFS, 32'(1 << b), 4'hF);
            outs(4'(1 << (b / 2)), b % 2 == 1, b % 2 == 1);
            outs(~4'(1 << (b / 2)), b % 2 == 0, b % 2 == 0);
        end
        bus(1'b1, LCIG_GLS0_OFS, 32'hFFFFFFA5, 4'hF);
        rdchk("gls", LCIG_GLS0_OFS, 32'hA5);
        outs(4'h3, 1'b0, 1'b0);
        outs(4'h1, 1'b1, 1'b1);
        bus(1'b1, LCIG_GLS0_OFS, 32'h0, 4'hE);
        rdchk("gls_nosel", LCIG_GLS0_OFS, 32'hA5);
        bus(1'b1, LCIG_POL_OFS, 32'h01, 4'hF);
        outs(4'h3, 1'b1, 1'b1);
        bus(1'b1, LCIG_POL_OFS, 32'hFF, 4'hF);
        rdchk("pol", LCIG_POL_OFS, 32'h81);
        outs(4'h3, 1'b1, 1'b0);
        outs(4'h1, 1'b0, 1'b1);
        bus(1'b1, 8'h40, 32'hFF, 4'hF);
        rdchk("unmapped", 8'h40, 32'h0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("gls_kept", LCIG_GLS0_OFS, 32'hA5);
        rdchk("sel_kept", LCIG_SEL3_OFS, {27'h0, codes[3]});
        rdchk("pol_kept", LCIG_POL_OFS, 32'h01);
        outs(4'h3, 1'b1, 1'b1);
        rdchk("stat", LCIG_STAT_OFS, 32'h33);
        stop_test();
    end
endmodule : lcig_top_bench
